// ### sys_config_regs.sv
`timescale 1ns/1ps
module sys_config_regs
  import sysctl_pkg::*;
#(
  parameter int IMPL_BITS = PRIO_IMPL_BITS_DEF
)
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire reg_req_t req,
  input wire logic nonsecure_fault_target,
  output logic [31:0] rdata,
  output cfg_bank_t cfg_s,
  output cfg_bank_t cfg_ns,
  output logic bus_fault_a_neg_prio_ignore,
  output prio_set_t prio_s,
  output prio_set_t prio_ns,
  output logic [7:0] bus_fault_a_prio,
  output logic [7:0] secure_fault_c_prio
);

  // byte lane write enable for one register offset
  function automatic logic lane_we(input reg_req_t r, input logic [7:0] ofs, input int lane);
    lane_we = r.wr && (r.addr == ofs) && r.be[lane];
  endfunction : lane_we

  // byte from the write word for one lane
  function automatic logic [7:0] lane_byte(input logic [31:0] w, input int lane);
    lane_byte = w[lane*8 +: 8];
  endfunction : lane_byte

  // configuration word as one security state sees it
  function automatic logic [31:0] ccr_word(input cfg_bank_t c, input logic bf_ign);
    logic [31:0] w;
    w = WORD_ZERO;
    w[BIT_BRANCH_PREDICT] = 1'b0;
    w[BIT_ICACHE] = 1'b0;
    w[BIT_DCACHE] = 1'b0;
    w[BIT_STACK_IGN] = c.stack_limit_neg_prio_ignore;
    w[BIT_RES1_HI] = 1'b1;
    w[BIT_BUS_FAULT_A_IGN] = bf_ign;
    w[BIT_ZERO_DIV] = c.zero_divide_trap_en;
    w[BIT_MISALIGN] = c.misalign_trap_en;
    w[BIT_UNPRIV_IRQ] = c.unpriv_sw_irq_allow;
    w[BIT_RES1_LO] = 1'b1;
    ccr_word = w;
  endfunction : ccr_word

  logic is_sec;
  logic bf_visible;
  logic ccr_we_lo;
  logic ccr_we_hi;
  logic bf_ign_r;
  logic [31:0] rdata_r;
  logic [31:0] rd_word;

  logic [7:0] mem_s;
  logic [7:0] mem_ns;
  logic [7:0] usage_s;
  logic [7:0] usage_ns;
  logic [7:0] svc_s;
  logic [7:0] svc_ns;
  logic [7:0] pend_s;
  logic [7:0] pend_ns;
  logic [7:0] tick_s;
  logic [7:0] tick_ns;
  logic [7:0] bus_q;
  logic [7:0] sec_q;

  assign is_sec = req.secure;
  // nonsecure side only reaches the bus fault field when faults target it
  assign bf_visible = is_sec || nonsecure_fault_target;

  assign ccr_we_lo = lane_we(req, OFS_CCR, 0);
  assign ccr_we_hi = lane_we(req, OFS_CCR, 1);

  // banked configuration bits: one copy per security state
  ccr_bank u_ccr_s
  (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .we_lo(ccr_we_lo && is_sec),
    .we_hi(ccr_we_hi && is_sec),
    .wdata(req.wdata),
    .cfg(cfg_s)
  );

  ccr_bank u_ccr_ns
  (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .we_lo(ccr_we_lo && !is_sec),
    .we_hi(ccr_we_hi && !is_sec),
    .wdata(req.wdata),
    .cfg(cfg_ns)
  );

  // shared between states: either state writes the one copy
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      bf_ign_r <= CFG_BIT_RESET;
    else if (ccr_we_hi)
      bf_ign_r <= req.wdata[BIT_BUS_FAULT_A_IGN];
  end

  assign bus_fault_a_neg_prio_ignore = bf_ign_r;

  // memory management fault priority, banked
  prio_byte #(.IMPL_BITS(IMPL_BITS)) u_mem_s
  (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .we(lane_we(req, OFS_PRIO_A, LANE_MEMFAULT) && is_sec),
    .wbyte(lane_byte(req.wdata, LANE_MEMFAULT)),
    .q(mem_s)
  );

  prio_byte #(.IMPL_BITS(IMPL_BITS)) u_mem_ns
  (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .we(lane_we(req, OFS_PRIO_A, LANE_MEMFAULT) && !is_sec),
    .wbyte(lane_byte(req.wdata, LANE_MEMFAULT)),
    .q(mem_ns)
  );

  // bus fault priority: single copy, nonsecure access gated
  prio_byte #(.IMPL_BITS(IMPL_BITS)) u_bus
  (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .we(lane_we(req, OFS_PRIO_A, LANE_BUS_FAULT_A) && bf_visible),
    .wbyte(lane_byte(req.wdata, LANE_BUS_FAULT_A)),
    .q(bus_q)
  );

  // usage fault priority, banked
  prio_byte #(.IMPL_BITS(IMPL_BITS)) u_usage_s
  (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .we(lane_we(req, OFS_PRIO_A, LANE_USAGE_FAULT_B) && is_sec),
    .wbyte(lane_byte(req.wdata, LANE_USAGE_FAULT_B)),
    .q(usage_s)
  );

  prio_byte #(.IMPL_BITS(IMPL_BITS)) u_usage_ns
  (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .we(lane_we(req, OFS_PRIO_A, LANE_USAGE_FAULT_B) && !is_sec),
    .wbyte(lane_byte(req.wdata, LANE_USAGE_FAULT_B)),
    .q(usage_ns)
  );

  // secure fault priority: only the secure state may touch it
  prio_byte #(.IMPL_BITS(IMPL_BITS)) u_secf
  (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .we(lane_we(req, OFS_PRIO_A, LANE_SECURE_FAULT_C) && is_sec),
    .wbyte(lane_byte(req.wdata, LANE_SECURE_FAULT_C)),
    .q(sec_q)
  );

  // supervisor call priority, banked
  prio_byte #(.IMPL_BITS(IMPL_BITS)) u_svc_s
  (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .we(lane_we(req, OFS_PRIO_SVC, LANE_SVC) && is_sec),
    .wbyte(lane_byte(req.wdata, LANE_SVC)),
    .q(svc_s)
  );

  prio_byte #(.IMPL_BITS(IMPL_BITS)) u_svc_ns
  (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .we(lane_we(req, OFS_PRIO_SVC, LANE_SVC) && !is_sec),
    .wbyte(lane_byte(req.wdata, LANE_SVC)),
    .q(svc_ns)
  );

  // pendable service and tick priorities, banked
  prio_byte #(.IMPL_BITS(IMPL_BITS)) u_pend_s
  (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .we(lane_we(req, OFS_PRIO_TICK, LANE_PENDABLE) && is_sec),
    .wbyte(lane_byte(req.wdata, LANE_PENDABLE)),
    .q(pend_s)
  );

  prio_byte #(.IMPL_BITS(IMPL_BITS)) u_pend_ns
  (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .we(lane_we(req, OFS_PRIO_TICK, LANE_PENDABLE) && !is_sec),
    .wbyte(lane_byte(req.wdata, LANE_PENDABLE)),
    .q(pend_ns)
  );

  prio_byte #(.IMPL_BITS(IMPL_BITS)) u_tick_s
  (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .we(lane_we(req, OFS_PRIO_TICK, LANE_TICK) && is_sec),
    .wbyte(lane_byte(req.wdata, LANE_TICK)),
    .q(tick_s)
  );

  prio_byte #(.IMPL_BITS(IMPL_BITS)) u_tick_ns
  (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .we(lane_we(req, OFS_PRIO_TICK, LANE_TICK) && !is_sec),
    .wbyte(lane_byte(req.wdata, LANE_TICK)),
    .q(tick_ns)
  );

  assign prio_s = {mem_s, usage_s, svc_s, pend_s, tick_s};
  assign prio_ns = {mem_ns, usage_ns, svc_ns, pend_ns, tick_ns};
  assign bus_fault_a_prio = bus_q;
  assign secure_fault_c_prio = sec_q;

  // read word as seen by the accessing state; unmapped offsets read zero
  always_comb
  begin
    rd_word = WORD_ZERO;
    case (req.addr)
      OFS_CCR:
      begin
        if (is_sec)
          rd_word = ccr_word(cfg_s, bf_ign_r);
        else
          rd_word = ccr_word(cfg_ns, bf_ign_r);
      end
      OFS_PRIO_A:
      begin
        rd_word[LANE_MEMFAULT*8 +: 8] = is_sec ? mem_s : mem_ns;
        rd_word[LANE_BUS_FAULT_A*8 +: 8] = bf_visible ? bus_q : 8'h00;
        rd_word[LANE_USAGE_FAULT_B*8 +: 8] = is_sec ? usage_s : usage_ns;
        rd_word[LANE_SECURE_FAULT_C*8 +: 8] = is_sec ? sec_q : 8'h00;
      end
      OFS_PRIO_SVC:
      begin
        // lower three lanes are reserved and stay zero
        rd_word[LANE_SVC*8 +: 8] = is_sec ? svc_s : svc_ns;
      end
      OFS_PRIO_TICK:
      begin
        rd_word[LANE_PENDABLE*8 +: 8] = is_sec ? pend_s : pend_ns;
        rd_word[LANE_TICK*8 +: 8] = is_sec ? tick_s : tick_ns;
      end
      default:
      begin
        rd_word = WORD_ZERO;
      end
    endcase
  end

  // read data valid only in the cycle after the strobe, zero otherwise
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      rdata_r <= WORD_ZERO;
    else if (req.rd)
      rdata_r <= rd_word;
    else
      rdata_r <= WORD_ZERO;
  end

  assign rdata = rdata_r;

endmodule : sys_config_regs

// ### sysctl_pkg.sv
// Operation
// - cache and predictor enable bits read zero
// - bit 10 ignores stack faults, banked
// - bit 8 ignores precise bus faults, shared
// - bit 4 enables divide by zero fault, banked
// - bit 3 enables misaligned access trap, banked
// - bit 1 lets unprivileged software pend irqs
// - priority fields hold 8 levels by default, 0 to 224 in steps of 32
// - priority registers take single byte accesses
// - priority fields banked per security state, except the single bus fault and secure fault fields
// - low priority bits read zero, ignore writes
// - memory fault priority in bits 7:0, banked
// - bus fault priority hidden from nonsecure unless targeted
// - usage fault priority in bits 23:16, banked
// - secure fault priority hidden from nonsecure state
// - supervisor call priority in bits 31:24, banked
// - third register holds pendable and tick priorities
package sysctl_pkg;

  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CCR = 8'h00;
  localparam logic [7:0] OFS_PRIO_A = 8'h04;
  localparam logic [7:0] OFS_PRIO_SVC = 8'h08;
  localparam logic [7:0] OFS_PRIO_TICK = 8'h0C;

  localparam int BIT_BRANCH_PREDICT = 18;
  localparam int BIT_ICACHE = 17;
  localparam int BIT_DCACHE = 16;
  localparam int BIT_STACK_IGN = 10;
  localparam int BIT_RES1_HI = 9;
  localparam int BIT_BUS_FAULT_A_IGN = 8;
  localparam int BIT_ZERO_DIV = 4;
  localparam int BIT_MISALIGN = 3;
  localparam int BIT_UNPRIV_IRQ = 1;
  localparam int BIT_RES1_LO = 0;

  localparam int LANE_MEMFAULT = 0;
  localparam int LANE_BUS_FAULT_A = 1;
  localparam int LANE_USAGE_FAULT_B = 2;
  localparam int LANE_SECURE_FAULT_C = 3;
  localparam int LANE_SVC = 3;
  localparam int LANE_PENDABLE = 2;
  localparam int LANE_TICK = 3;

  localparam int PRIO_IMPL_BITS_DEF = 3;
  localparam logic [7:0] PRIO_RESET = 8'h00;
  localparam logic CFG_BIT_RESET = 1'b0;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic [3:0] be;
    logic wr;
    logic rd;
    logic secure;
  } reg_req_t;

  typedef struct packed {
    logic stack_limit_neg_prio_ignore;
    logic zero_divide_trap_en;
    logic misalign_trap_en;
    logic unpriv_sw_irq_allow;
  } cfg_bank_t;

  typedef struct packed {
    logic [7:0] memfault_prio;
    logic [7:0] usage_fault_b_prio;
    logic [7:0] svc_prio;
    logic [7:0] pendable_service_prio;
    logic [7:0] tick_prio;
  } prio_set_t;

endpackage : sysctl_pkg

// ### prio_byte.sv
`timescale 1ns/1ps
module prio_byte
  import sysctl_pkg::*;
#(
  parameter int IMPL_BITS = PRIO_IMPL_BITS_DEF
)
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic we,
  input wire logic [7:0] wbyte,
  output logic [7:0] q
);

  // storing all eight bits keeps the field byte aligned; unused bits are constant
  localparam logic [7:0] IMPL_MASK = 8'(16'h00FF << (8 - IMPL_BITS));

  logic [7:0] val_r;

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      val_r <= PRIO_RESET;
    else if (we)
      val_r <= wbyte & IMPL_MASK;
  end

  assign q = val_r;

endmodule : prio_byte

// ### ccr_bank.sv
`timescale 1ns/1ps
module ccr_bank
  import sysctl_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic we_lo,
  input wire logic we_hi,
  input wire logic [31:0] wdata,
  output cfg_bank_t cfg
);

  // one variable per bit so each always_ff owns what it writes
  logic stack_ign_r;
  logic zero_div_r;
  logic misalign_r;
  logic unpriv_irq_r;

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      stack_ign_r <= CFG_BIT_RESET;
    else if (we_hi)
      stack_ign_r <= wdata[BIT_STACK_IGN];
  end

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      zero_div_r <= CFG_BIT_RESET;
      misalign_r <= CFG_BIT_RESET;
      unpriv_irq_r <= CFG_BIT_RESET;
    end
    else if (we_lo)
    begin
      zero_div_r <= wdata[BIT_ZERO_DIV];
      misalign_r <= wdata[BIT_MISALIGN];
      unpriv_irq_r <= wdata[BIT_UNPRIV_IRQ];
    end
  end

  assign cfg = {stack_ign_r, zero_div_r, misalign_r, unpriv_irq_r};

endmodule : ccr_bank

// ### sys_config_props.sv
`timescale 1ns/1ps
module sys_config_props
  import sysctl_pkg::*;
#(
  parameter int IMPL_BITS = PRIO_IMPL_BITS_DEF
)
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire reg_req_t req,
  input wire logic nonsecure_fault_target,
  input wire logic [31:0] rdata,
  input wire cfg_bank_t cfg_s,
  input wire cfg_bank_t cfg_ns,
  input wire logic bus_fault_a_neg_prio_ignore,
  input wire prio_set_t prio_s,
  input wire prio_set_t prio_ns,
  input wire logic [7:0] bus_fault_a_prio,
  input wire logic [7:0] secure_fault_c_prio
);
  localparam logic [7:0] LOW_M = 8'hFF >> IMPL_BITS;
  wire rd_ccr = req.rd && req.addr == OFS_CCR;
  wire wr_a = req.wr && req.addr == OFS_PRIO_A;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  a_ccr_fixed_bits: assert property (rd_ccr |=> (rdata & 32'hFFFF_FAE5) == 32'h0000_0201)
    else $error("config fixed bits wrong");
  a_ccr_secure_copy: assert property (rd_ccr && req.secure |=>
    {rdata[10], rdata[4], rdata[3], rdata[1]} == $past(cfg_s)) else $error("secure copy wrong");
  a_ccr_ns_copy: assert property (rd_ccr && !req.secure |=>
    {rdata[10], rdata[4], rdata[3], rdata[1]} == $past(cfg_ns)) else $error("ns copy wrong");
  a_ccr_shared_bit: assert property (rd_ccr |=> rdata[8] == $past(bus_fault_a_neg_prio_ignore))
    else $error("shared bit wrong");
  a_prio_low_zero: assert property ((({prio_s, prio_ns} & {10{LOW_M}}) == '0)
    && (((bus_fault_a_prio | secure_fault_c_prio) & LOW_M) == 8'h00)) else $error("low bits set");
  a_ns_write_safe: assert property (req.wr && !req.secure |=> $stable(prio_s)
    && $stable(cfg_s) && $stable(secure_fault_c_prio)) else $error("ns write hit secure");
  a_busprio_ns_lock: assert property (req.wr && !req.secure && !nonsecure_fault_target
    |=> $stable(bus_fault_a_prio)) else $error("bus prio written");
  a_mem_byte_write: assert property (wr_a && req.secure && req.be[0] |=>
    prio_s.memfault_prio == ($past(req.wdata[7:0]) & ~LOW_M)) else $error("mem prio wrong");
  a_svc_ns_write: assert property (req.wr && !req.secure && req.addr == OFS_PRIO_SVC
    && req.be[3] |=> prio_ns.svc_prio == ($past(req.wdata[31:24]) & ~LOW_M))
    else $error("svc prio wrong");
  c_ccr_read: cover property (rd_ccr && req.secure);
  c_bus_ns: cover property (wr_a && !req.secure && nonsecure_fault_target);
  c_svc: cover property (req.wr && req.addr == OFS_PRIO_SVC);
endmodule : sys_config_props

bind sys_config_regs sys_config_props #(.IMPL_BITS(IMPL_BITS)) sys_config_props_inst (
  .ref_clk(ref_clk),
  .resetn(resetn),
  .req(req),
  .nonsecure_fault_target(nonsecure_fault_target),
  .rdata(rdata),
  .cfg_s(cfg_s),
  .cfg_ns(cfg_ns),
  .bus_fault_a_neg_prio_ignore(bus_fault_a_neg_prio_ignore),
  .prio_s(prio_s),
  .prio_ns(prio_ns),
  .bus_fault_a_prio(bus_fault_a_prio),
  .secure_fault_c_prio(secure_fault_c_prio)
);

// ### sys_config_regs_bench.sv
`timescale 1ns/1ps
module sys_config_regs_bench;
  import sysctl_pkg::*;
  localparam int IMPL = 3;
  localparam logic [7:0] HI = 8'hFF << (8 - IMPL);
  logic ref_clk;
  logic resetn;
  reg_req_t req;
  logic nonsecure_fault_target;
  logic [31:0] rdata;
  cfg_bank_t cfg_s;
  cfg_bank_t cfg_ns;
  logic bus_fault_a_neg_prio_ignore;
  prio_set_t prio_s;
  prio_set_t prio_ns;
  logic [7:0] bus_fault_a_prio;
  logic [7:0] secure_fault_c_prio;
  int n_errors = 0;
  int comparisons = 0;

  sys_config_regs #(.IMPL_BITS(IMPL)) sys_config_regs_inst (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .req(req),
    .nonsecure_fault_target(nonsecure_fault_target),
    .rdata(rdata),
    .cfg_s(cfg_s),
    .cfg_ns(cfg_ns),
    .bus_fault_a_neg_prio_ignore(bus_fault_a_neg_prio_ignore),
    .prio_s(prio_s),
    .prio_ns(prio_ns),
    .bus_fault_a_prio(bus_fault_a_prio),
    .secure_fault_c_prio(secure_fault_c_prio)
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be, input logic s);
    @(posedge ref_clk);
    req <= '{addr: a, wdata: d, be: be, wr: 1'b1, rd: 1'b0, secure: s};
    @(posedge ref_clk);
    req.wr <= 1'b0;
  endtask : wr

  // rdata stands only in the cycle after the strobe, so it is sampled just past that edge
  task automatic rd(input string nm, input logic [7:0] a, input logic s, input logic [31:0] exp);
    @(posedge ref_clk);
    req <= '{addr: a, wdata: 32'h0, be: 4'h0, wr: 1'b0, rd: 1'b1, secure: s};
    @(posedge ref_clk);
    req.rd <= 1'b0;
    #1;
    check(nm, exp, rdata);
  endtask : rd

  task automatic t_reset;
    rd("ccr s", OFS_CCR, 1'b1, 32'h0000_0201);
    rd("ccr ns", OFS_CCR, 1'b0, 32'h0000_0201);
    rd("prio a", OFS_PRIO_A, 1'b1, WORD_ZERO);
    wr(8'h40, 32'hFFFF_FFFF, 4'hF, 1'b1);
    rd("unmapped", 8'h40, 1'b1, WORD_ZERO);
    $display("test reset done");
  endtask : t_reset

  task automatic t_ccr;
    wr(OFS_CCR, 32'hFFFF_FFFF, 4'hF, 1'b1);
    rd("ccr s all", OFS_CCR, 1'b1, 32'h0000_071B);
    rd("ccr ns", OFS_CCR, 1'b0, 32'h0000_0301);
    wr(OFS_CCR, 32'h0000_0412, 4'hF, 1'b0);
    rd("ccr ns set", OFS_CCR, 1'b0, 32'h0000_0613);
    rd("ccr s kept", OFS_CCR, 1'b1, 32'h0000_061B);
    check("bf ignore", WORD_ZERO, {31'h0, bus_fault_a_neg_prio_ignore});
    check("cfg_ns", 32'h0000_000D, {28'h0, cfg_ns});
    check("cfg_s", 32'h0000_000F, {28'h0, cfg_s});
    $display("test ccr done");
  endtask : t_ccr

  task automatic t_prio;
    wr(OFS_PRIO_A, 32'hFFFF_FFFF, 4'b0001, 1'b1);
    wr(OFS_PRIO_A, 32'hFFFF_FFFF, 4'b1100, 1'b1);
    rd("a s", OFS_PRIO_A, 1'b1, {HI, HI, 8'h00, HI});
    rd("a ns", OFS_PRIO_A, 1'b0, WORD_ZERO);
    wr(OFS_PRIO_A, 32'hFFFF_FFFF, 4'hF, 1'b0);
    rd("a ns wr", OFS_PRIO_A, 1'b0, {8'h00, HI, 8'h00, HI});
    nonsecure_fault_target <= 1'b1;
    wr(OFS_PRIO_A, 32'h0000_A500, 4'b0010, 1'b0);
    rd("bus ns", OFS_PRIO_A, 1'b0, {8'h00, HI, 8'hA5 & HI, HI});
    rd("bus s", OFS_PRIO_A, 1'b1, {HI, HI, 8'hA5 & HI, HI});
    nonsecure_fault_target <= 1'b0;
    rd("bus hid", OFS_PRIO_A, 1'b0, {8'h00, HI, 8'h00, HI});
    check("bus prio", {24'h0, 8'hA5 & HI}, {24'h0, bus_fault_a_prio});
    check("sec prio", {24'h0, HI}, {24'h0, secure_fault_c_prio});
    check("usage ns", {24'h0, HI}, {24'h0, prio_ns.usage_fault_b_prio});
    check("mem s", {24'h0, HI}, {24'h0, prio_s.memfault_prio});
    $display("test prio done");
  endtask : t_prio

  task automatic t_svc;
    wr(OFS_PRIO_SVC, 32'hFFFF_FFFF, 4'hF, 1'b1);
    rd("svc s", OFS_PRIO_SVC, 1'b1, {HI, 24'h0});
    rd("svc ns", OFS_PRIO_SVC, 1'b0, WORD_ZERO);
    wr(OFS_PRIO_SVC, 32'h5AFF_FFFF, 4'hF, 1'b0);
    rd("svc ns wr", OFS_PRIO_SVC, 1'b0, {8'h5A & HI, 24'h0});
    wr(OFS_PRIO_SVC, WORD_ZERO, 4'b1000, 1'b1);
    rd("svc s zero", OFS_PRIO_SVC, 1'b1, WORD_ZERO);
    wr(OFS_PRIO_TICK, 32'hFFFF_FFFF, 4'hF, 1'b1);
    rd("tick s", OFS_PRIO_TICK, 1'b1, {HI, HI, 16'h0});
    check("svc ns", {24'h0, 8'h5A & HI}, {24'h0, prio_ns.svc_prio});
    check("pend s", {24'h0, HI}, {24'h0, prio_s.pendable_service_prio});
    check("tick ns", WORD_ZERO, {24'h0, prio_ns.tick_prio});
    $display("test svc done");
  endtask : t_svc

  // reset in mid-run must clear every stored field again
  task automatic t_midreset;
    @(posedge ref_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    rd("tick rst", OFS_PRIO_TICK, 1'b1, WORD_ZERO);
    rd("ccr rst", OFS_CCR, 1'b1, 32'h0000_0201);
    check("bus prio rst", WORD_ZERO, {24'h0, bus_fault_a_prio});
    $display("test midreset done");
  endtask : t_midreset

  task automatic stop_test;
    $display("comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test

  // the tests need about 70 cycles; anything past this is a hang
  initial
  begin
    repeat (2000) @(posedge ref_clk);
    $display("Error watchdog expected done seen timeout");
    n_errors++;
    stop_test();
  end

  initial
  begin
    req = '0;
    resetn = 1'b0;
    nonsecure_fault_target = 1'b0;
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    t_reset();
    t_ccr();
    t_prio();
    t_svc();
    t_midreset();
    stop_test();
  end
endmodule : sys_config_regs_bench
